/* File: logic/adc_seq_pkg.sv */
// Package with register map, field layout, timing and types for the ADC sequencer.
package adc_seq_pkg;

  // Byte addresses of the two control registers on the register bus.
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;

  // Field positions in the first control register.
  localparam int POS_TWELVE_BIT = 10;
  localparam int POS_FORM = 8;
  localparam int POS_TRIGGER = 5;
  localparam int POS_SIMULTANEOUS = 3;
  localparam int POS_AUTO_START = 2;
  localparam int POS_ACQUIRE = 1;
  localparam int POS_DONE = 0;

  // Field positions in the second control register.
  localparam int POS_REFERENCE = 13;
  localparam int POS_SCAN = 10;
  localparam int POS_CHANNEL_COUNT = 8;
  localparam int POS_BUFFER_HALF = 7;
  localparam int POS_DMA_RATE = 2;
  localparam int POS_FILL_MODE = 1;
  localparam int POS_ALTERNATE = 0;

  // Trigger source encodings.
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_PIN = 3'h1;
  localparam logic [2:0] TRIG_TIMER = 3'h2;
  localparam logic [2:0] TRIG_ALT = 3'h3;
  localparam logic [2:0] TRIG_AUTO = 3'h7;

  // Timing: clock period, one conversion, and the internal sampling time.
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONV_TIME_NS = 48;
  localparam int AUTO_SAMPLE_TIME_NS = 64;
  localparam int CONV_CYCLES_INT = (CONV_TIME_NS + CLK_PERIOD_NS - 1) /
                                   CLK_PERIOD_NS;
  localparam int AUTO_CYCLES_INT = (AUTO_SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) /
                                   CLK_PERIOD_NS;
  localparam logic [7:0] CONV_CYCLES = 8'(CONV_CYCLES_INT);
  localparam logic [7:0] AUTO_CYCLES = 8'(AUTO_CYCLES_INT);

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset value of all stored configuration.
  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // Writable settings of the first control register.
  typedef struct packed {
    logic twelve_bit_mode;
    logic [1:0] form;
    logic [2:0] trigger_source_select;
    logic simultaneous_acquire;
    logic auto_acquire_start;
  } ctl_one_t;

  // Writable settings of the second control register.
  typedef struct packed {
    logic [2:0] reference_config;
    logic input_scan_enable;
    logic [1:0] channel_count_select;
    logic [3:0] dma_increment_rate;
    logic buffer_fill_mode;
    logic alternate_input_select;
  } ctl_two_t;

  // Phases of the sample and convert sequence.
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SAMPLING,
    PH_CONVERTING
  } phase_t;

endpackage

/* File: logic/conv_timer.sv */
// Down-counter that times one conversion burst and flags its end.
`timescale 1ns/1ns
module conv_timer
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] length,
  output logic busy,
  output logic finish
);

  // Cycles left in the running burst; zero means idle.
  logic [7:0] count;
  logic [7:0] next_count;
  logic next_finish;

  // Load on start, count down, and pulse finish in the cycle after the last one.
  always_comb begin
    next_count = count;
    next_finish = 1'b0;
    if (start) begin
      next_count = length;
    end else if (count != 8'h00) begin
      next_count = count - 8'h01;
      next_finish = (count == 8'h01);
    end
  end

  // Registers only.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= 8'h00;
      finish <= 1'b0;
    end else begin
      count <= next_count;
      finish <= next_finish;
    end
  end

  // Busy while cycles remain, so a start is never missed by the caller.
  assign busy = (count != 8'h00);

endmodule

/* File: logic/adc_sample_conversion_control.sv */
// Sample and convert sequencer for the ADC with an AXI4-Lite register slave.
//
// Summary of operation
// - Simultaneous, count 1x: all four together.
// - Simultaneous, count 01: CH0 and CH1 together.
// - Simultaneous clear: channels sampled one by one.
// - Simultaneous ignored with single channel selected.
// - Twelve-bit mode: simultaneous bit reads zero.
// - Auto start resamples after each conversion.
// - Acquire bit one while tracking, zero holding.
// - Other sources: trigger clears acquire, starts conversion.
// - Done bit set when a conversion finishes.
// - Software clears done by zero; one ignored.
// - Clearing done leaves conversions undisturbed.
// - Done bit cleared when a conversion starts.
// - Source 111: internal counter ends sampling.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
module adc_sample_conversion_control
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_trigger_pin,
  input wire logic timer_compare_event,
  input wire logic alt_trigger_event,
  output logic [3:0] track_channels,
  output logic [1:0] convert_channel,
  output logic conversion_busy,
  output logic conversion_done
);

  // Stored settings and sequencer state.
  ctl_one_t one;
  ctl_two_t two;
  phase_t phase;
  logic done_flag;
  logic buffer_half;
  logic [1:0] chan;
  logic [7:0] auto_count;
  ctl_one_t next_one;
  ctl_two_t next_two;
  phase_t next_phase;
  logic next_done_flag;
  logic next_buffer_half;
  logic [1:0] next_chan;
  logic [7:0] next_auto_count;
  logic [3:0] next_track;

  // Bus channel state: latched address and data, pending answers.
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_full;
  logic next_w_full;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // Pin synchroniser; only the second and third stages are compared.
  logic [2:0] pin_sync;
  logic pin_level;
  logic next_pin_level;

  // Timer interface.
  logic conv_start;
  logic [7:0] conv_length;
  logic conv_finish;
  logic timer_busy;

  // Decoded helpers.
  logic [2:0] conv_total;
  logic [1:0] count_eff;
  logic simul_eff;
  logic trigger_fire;
  logic wr_go;
  logic wr_one;
  logic wr_two;
  logic [15:0] wr_val;

  // Number of channels that the count field selects.
  function automatic logic [2:0] channels_of(input logic [1:0] cnt);
    channels_of = cnt[1] ? 3'h4 : (cnt[0] ? 3'h2 : 3'h1);
  endfunction

  // Merge write data into a 16-bit register honouring the two low lanes.
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    if (strb[0]) begin
      merge[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge[15:8] = data[15:8];
    end
  endfunction

  // Register image of the first control register.
  function automatic logic [15:0] image_one(input ctl_one_t c,
                                            input logic acq,
                                            input logic dn);
    image_one = RESET_VALUE;
    image_one[POS_TWELVE_BIT] = c.twelve_bit_mode;
    image_one[POS_FORM +: 2] = c.form;
    image_one[POS_TRIGGER +: 3] = c.trigger_source_select;
    image_one[POS_SIMULTANEOUS] = c.simultaneous_acquire;
    image_one[POS_AUTO_START] = c.auto_acquire_start;
    image_one[POS_ACQUIRE] = acq;
    image_one[POS_DONE] = dn;
  endfunction

  // Register image of the second control register.
  function automatic logic [15:0] image_two(input ctl_two_t c,
                                            input logic half);
    image_two = RESET_VALUE;
    image_two[POS_REFERENCE +: 3] = c.reference_config;
    image_two[POS_SCAN] = c.input_scan_enable;
    image_two[POS_CHANNEL_COUNT +: 2] = c.channel_count_select;
    image_two[POS_BUFFER_HALF] = half;
    image_two[POS_DMA_RATE +: 4] = c.dma_increment_rate;
    image_two[POS_FILL_MODE] = c.buffer_fill_mode;
    image_two[POS_ALTERNATE] = c.alternate_input_select;
  endfunction

  // The stored fields are already forced to zero in twelve-bit mode.
  assign count_eff = two.channel_count_select;
  assign simul_eff = one.simultaneous_acquire && (count_eff != 2'h0);
  assign conv_total = channels_of(count_eff);

  // Bus handshakes: each holding stage accepts while empty.
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_full && w_full && !s_axi_bvalid;
  assign wr_one = wr_go && (aw_addr == ADDR_CONTROL_ONE);
  assign wr_two = wr_go && (aw_addr == ADDR_CONTROL_TWO);

  // Pin, timer, alternate and internal-counter sources end the sampling phase.
  always_comb begin
    trigger_fire = 1'b0;
    next_pin_level = pin_level;
    if (pin_sync[2] == pin_sync[1]) begin
      next_pin_level = pin_sync[1];
    end
    unique case (one.trigger_source_select)
      TRIG_PIN: trigger_fire = next_pin_level && !pin_level;
      TRIG_TIMER: trigger_fire = timer_compare_event;
      TRIG_ALT: trigger_fire = alt_trigger_event;
      TRIG_AUTO: trigger_fire = (auto_count == AUTO_CYCLES);
      default: trigger_fire = 1'b0;
    endcase
  end

  // Bus write and read channel bookkeeping.
  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      // Both halves present: answer, and free the stages.
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wr_one || wr_two) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_axi_rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      if (s_axi_araddr == ADDR_CONTROL_ONE) begin
        next_rdata = {16'h0000,
                      image_one(one, phase == PH_SAMPLING, done_flag)};
      end else if (s_axi_araddr == ADDR_CONTROL_TWO) begin
        next_rdata = {16'h0000, image_two(two, buffer_half)};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end
    end
  end

  // Sequencer: configuration writes, sampling and conversion phases.
  always_comb begin
    next_one = one;
    next_two = two;
    next_phase = phase;
    next_done_flag = done_flag;
    next_buffer_half = buffer_half;
    next_chan = chan;
    next_auto_count = auto_count;
    next_track = 4'h0;
    conv_start = 1'b0;
    conv_length = CONV_CYCLES;
    wr_val = RESET_VALUE;
    if (wr_one) begin
      wr_val = merge(image_one(one, phase == PH_SAMPLING, done_flag),
                     w_data, w_strb);
      next_one.twelve_bit_mode = wr_val[POS_TWELVE_BIT];
      next_one.form = wr_val[POS_FORM +: 2];
      next_one.trigger_source_select = wr_val[POS_TRIGGER +: 3];
      next_one.simultaneous_acquire = wr_val[POS_SIMULTANEOUS] &&
                                      !wr_val[POS_TWELVE_BIT];
      next_one.auto_acquire_start = wr_val[POS_AUTO_START];
      if (!wr_val[POS_DONE]) begin
        next_done_flag = 1'b0;
      end
    end
    if (wr_two) begin
      wr_val = merge(image_two(two, buffer_half), w_data, w_strb);
      next_two.reference_config = wr_val[POS_REFERENCE +: 3];
      next_two.input_scan_enable = wr_val[POS_SCAN];
      next_two.channel_count_select = one.twelve_bit_mode ? 2'h0 :
                                      wr_val[POS_CHANNEL_COUNT +: 2];
      next_two.dma_increment_rate = wr_val[POS_DMA_RATE +: 4];
      next_two.buffer_fill_mode = wr_val[POS_FILL_MODE];
      next_two.alternate_input_select = wr_val[POS_ALTERNATE];
    end
    if (next_one.twelve_bit_mode) begin
      // Twelve-bit mode is single channel; stale fields would mislead.
      next_one.simultaneous_acquire = 1'b0;
      next_two.channel_count_select = 2'h0;
    end
    unique case (phase)
      PH_IDLE: begin
        if (wr_one && wr_val[POS_ACQUIRE]) begin
          next_phase = PH_SAMPLING;
          next_auto_count = 8'h00;
        end
      end
      PH_SAMPLING: begin
        next_auto_count = (auto_count == AUTO_CYCLES) ? auto_count :
                          auto_count + 8'h01;
        if ((one.trigger_source_select == TRIG_MANUAL &&
             wr_one && !wr_val[POS_ACQUIRE]) ||
            (one.trigger_source_select != TRIG_MANUAL && trigger_fire)) begin
          next_phase = PH_CONVERTING;
          conv_start = 1'b1;
          conv_length = simul_eff ? 8'(CONV_CYCLES * conv_total) :
                        CONV_CYCLES;
          next_done_flag = 1'b0;
        end
      end
      PH_CONVERTING: begin
        if (conv_finish) begin
          next_done_flag = 1'b1;
          next_buffer_half = two.buffer_fill_mode ? !buffer_half : 1'b0;
          if (!simul_eff && (3'(chan) + 3'h1 < conv_total)) begin
            next_chan = chan + 2'h1;
          end else begin
            next_chan = 2'h0;
          end
          next_phase = one.auto_acquire_start ? PH_SAMPLING : PH_IDLE;
          next_auto_count = 8'h00;
        end
      end
    endcase
    if (next_phase == PH_SAMPLING) begin
      if (simul_eff) begin
        next_track = (conv_total == 3'h4) ? 4'hF : 4'h3;
      end else begin
        next_track = 4'(4'h1 << next_chan);
      end
    end
  end

  // Registers of the bus slave, the pin synchroniser and the sequencer.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      pin_sync <= 3'h0;
      pin_level <= 1'b0;
      one <= ctl_one_t'(RESET_VALUE[7:0]);
      two <= ctl_two_t'(RESET_VALUE[11:0]);
      phase <= PH_IDLE;
      done_flag <= 1'b0;
      buffer_half <= 1'b0;
      chan <= 2'h0;
      auto_count <= 8'h00;
      track_channels <= 4'h0;
      convert_channel <= 2'h0;
      conversion_done <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      pin_sync <= {pin_sync[1:0], ext_trigger_pin};
      pin_level <= next_pin_level;
      one <= next_one;
      two <= next_two;
      phase <= next_phase;
      done_flag <= next_done_flag;
      buffer_half <= next_buffer_half;
      chan <= next_chan;
      auto_count <= next_auto_count;
      track_channels <= next_track;
      convert_channel <= next_chan;
      conversion_done <= conv_finish;
    end
  end

  // Conversion timing lives in its own counter.
  conv_timer conv_timer_inst (
    .clk(clk),
    .resetn(resetn),
    .start(conv_start),
    .length(conv_length),
    .busy(timer_busy),
    .finish(conv_finish)
  );

  // Busy follows the timer, which keeps running whatever software clears.
  assign conversion_busy = timer_busy;

endmodule

/* File: tb/adc_ctl_props.sv */
// Concurrent checks on the sequencer and register bus ports.
`timescale 1ns/1ns
module adc_ctl_props
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] track_channels,
  input wire logic [1:0] convert_channel,
  input wire logic conversion_busy,
  input wire logic conversion_done
);
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Both halves of a write are taken at the same edge.
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // A conversion keeps the converter busy for eight cycles at least.
  sequence conv_run;
    conversion_busy [*8];
  endsequence

  done_after_busy_a:
    assert property (conversion_done |-> $past(conversion_busy) ||
      $past(conversion_busy, 2))
    else $error("done pulse without a conversion");
  done_single_a:
    assert property (conversion_done |=> !conversion_done)
    else $error("done pulse longer than one cycle");
  busy_min_a:
    assert property ($rose(conversion_busy) |-> conv_run)
    else $error("conversion ended too early");
  hold_in_conv_a:
    assert property (conversion_busy |-> track_channels == 4'h0)
    else $error("tracking while converting");
  track_pattern_a:
    assert property (track_channels inside {4'h0, 4'h1, 4'h2, 4'h4,
      4'h8, 4'h3, 4'hF})
    else $error("illegal tracking pattern");
  seq_channel_a:
    assert property ($onehot(track_channels) |->
      track_channels == (4'h1 << convert_channel))
    else $error("tracked channel differs from channel index");
  conv_from_track_a:
    assert property ($rose(conversion_busy) |-> $past(track_channels) != 0)
    else $error("conversion started without sampling");
  write_answer_a:
    assert property (write_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  read_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule

/* File: tb/adc_sample_conversion_control_bench.sv */
// Self-checking bench for the ADC sample and convert sequencer.
`timescale 1ns/1ns
module adc_sample_conversion_control_bench
  import adc_seq_pkg::*;
;
  logic clk, resetn; // Clock and active-low reset.
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, track_channels;
  logic [1:0] s_axi_bresp, s_axi_rresp, convert_channel;
  logic ext_trigger_pin, timer_compare_event, alt_trigger_event;
  logic conversion_busy, conversion_done;
  int miscompares, comparisons; // Outcome counters.

  adc_sample_conversion_control adc_sample_conversion_control_inst (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_trigger_pin, .timer_compare_event,
    .alt_trigger_event, .track_channels, .convert_channel,
    .conversion_busy, .conversion_done);

  // The clock toggles every 2 ns for a 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Write cycle; handshakes are judged at the falling edge because
  // inputs only move just after a rising edge.
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    output logic [1:0] resp);
    logic aw_hit, w_hit, b_hit;
    b_hit = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'h3;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_hit) begin
      @(negedge clk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  // Write whose response is not of interest.
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  // Read cycle in the same manner as the write; rready follows rvalid
  // one cycle late, so that a waiting read answer is also exercised.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    logic ar_hit, r_hit, r_seen;
    r_hit = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!r_hit) begin
      @(negedge clk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_seen = s_axi_rvalid;
      r_hit = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      s_axi_rready <= r_seen && !r_hit;
    end
  endtask

  // Reads a register and compares its contents.
  task automatic rc(input string what, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(what, d, exp);
  endtask

  // Counts cycles until the done pulse; a hang is reported, not waited out.
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!conversion_done && n < 300);
    check("done pulse seen", {31'h0, conversion_done}, 32'h1);
  endtask

  // Raises one trigger input; the pin is held long enough for its sync.
  task automatic fire(input logic [2:0] s);
    @(posedge clk);
    ext_trigger_pin <= (s == TRIG_PIN);
    timer_compare_event <= (s == TRIG_TIMER);
    alt_trigger_event <= (s == TRIG_ALT);
    repeat ((s == TRIG_PIN) ? 4 : 1) @(posedge clk);
    ext_trigger_pin <= 1'b0;
    timer_compare_event <= 1'b0;
    alt_trigger_event <= 1'b0;
    @(negedge clk);
  endtask

  // Reset values, read-only and unmapped places, twelve-bit masking.
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rc("control one reset", ADDR_CONTROL_ONE, 32'h00000000);
    rc("control two reset", ADDR_CONTROL_TWO, 32'h00000000);
    rd(8'h08, d, r);
    check("unmapped read", {d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(8'h0C, 16'hFFFF, r);
    check("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
    w(ADDR_CONTROL_TWO, 16'hFFFF);
    rc("control two fields", ADDR_CONTROL_TWO, 32'h0000E73F);
    w(ADDR_CONTROL_ONE, 16'h0408);
    rc("twelve bit simultaneous", ADDR_CONTROL_ONE, 32'h00000400);
    w(ADDR_CONTROL_ONE, 16'h0000);
    w(ADDR_CONTROL_TWO, 16'h0000);
  endtask

  // Manual sampling and the done bit's clearing behaviour.
  task automatic t_done();
    int n;
    w(ADDR_CONTROL_ONE, 16'h0002);
    check("manual tracking", {28'h0, track_channels}, 32'h1);
    rc("acquire reads one", ADDR_CONTROL_ONE, 32'h00000002);
    w(ADDR_CONTROL_ONE, 16'h0000);
    // Clearing done mid-conversion must not stop the conversion.
    w(ADDR_CONTROL_ONE, 16'h0000);
    wait_done(n);
    rc("done after conversion", ADDR_CONTROL_ONE, 32'h00000001);
    w(ADDR_CONTROL_ONE, 16'h0000);
    rc("done cleared by zero", ADDR_CONTROL_ONE, 32'h00000000);
    w(ADDR_CONTROL_ONE, 16'h0001);
    rc("done not set by one", ADDR_CONTROL_ONE, 32'h00000000);
  endtask

  // Timer trigger with auto restart over two channels in sequence.
  task automatic t_seq();
    int n;
    w(ADDR_CONTROL_TWO, 16'h0100);
    w(ADDR_CONTROL_ONE, 16'h0046);
    for (int k = 0; k < 3; k++) begin
      check("channel order", {28'h0, track_channels},
            32'h1 << (k % 2));
      fire(TRIG_TIMER);
      wait_done(n);
      repeat (2) @(negedge clk);
    end
    rc("auto restart", ADDR_CONTROL_ONE, 32'h00000047);
    fire(TRIG_TIMER);
    rc("done cleared at start", ADDR_CONTROL_ONE, 32'h00000044);
    w(ADDR_CONTROL_ONE, 16'h0040);
    wait_done(n);
    repeat (2) @(negedge clk);
    check("no restart", {28'h0, track_channels}, 32'h0);
    w(ADDR_CONTROL_ONE, 16'h0000);
    w(ADDR_CONTROL_TWO, 16'h0000);
  endtask

  // Every channel count with simultaneous sampling selected.
  task automatic t_simul();
    logic [3:0] trk [4] = '{4'h1, 4'h3, 4'hF, 4'hF};
    int mul [4] = '{1, 2, 4, 4};
    int n, lo, hi;
    for (int k = 0; k < 4; k++) begin
      w(ADDR_CONTROL_TWO, {6'h00, 2'(k), 8'h00});
      w(ADDR_CONTROL_ONE, 16'h000A);
      check("simultaneous tracking", {28'h0, track_channels},
            {28'h0, trk[k]});
      w(ADDR_CONTROL_ONE, 16'h0008);
      wait_done(n);
      lo = mul[k] * CONV_CYCLES_INT - 3;
      hi = mul[k] * CONV_CYCLES_INT + 2;
      check("burst length", {31'h0, n >= lo && n <= hi},
            32'h1);
    end
    w(ADDR_CONTROL_ONE, 16'h0000);
    w(ADDR_CONTROL_TWO, 16'h0000);
  endtask

  // Each trigger source except manual; a foreign trigger must leave sampling alone.
  task automatic t_sources();
    logic [2:0] src [4] = '{TRIG_PIN, TRIG_TIMER, TRIG_ALT, TRIG_AUTO};
    int n, nom;
    nom = AUTO_CYCLES_INT + CONV_CYCLES_INT;
    for (int k = 0; k < 4; k++) begin
      w(ADDR_CONTROL_ONE, {8'h00, src[k], 5'h02});
      if (src[k] != TRIG_AUTO) begin
        fire((src[k] == TRIG_PIN) ? TRIG_ALT : TRIG_PIN);
        check("foreign trigger", {28'h0, track_channels}, 32'h1);
        fire(src[k]);
      end
      wait_done(n);
      if (src[k] == TRIG_AUTO) begin
        check("auto convert time", {31'h0, n > nom - 4 && n < nom + 4},
              32'h1);
      end
    end
    w(ADDR_CONTROL_ONE, 16'h0000);
  endtask

  // Main sequence: reset for three cycles, then the scenarios.
  initial begin
    resetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    ext_trigger_pin = 1'b0;
    timer_compare_event = 1'b0;
    alt_trigger_event = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_done();
    t_seq();
    t_simul();
    t_sources();
    end_sim();
  end

  // Watchdog; the scenarios need well under a tenth of this span.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule

// Attach the checker to every instance of the sequencer.
bind adc_sample_conversion_control adc_ctl_props adc_ctl_props_inst (
  .clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .track_channels, .convert_channel, .conversion_busy, .conversion_done);
